//--- hdl/cpa_defs.vh
`ifndef CPA_DEFS_VH
`define CPA_DEFS_VH
// register offsets (byte addresses)
`define CPA_ADDR_WFIFO   8'h00
`define CPA_ADDR_RFIFO   8'h04
`define CPA_ADDR_CTRL    8'h08
`define CPA_ADDR_STATUS  8'h0C
`define CPA_ADDR_WCOUNT  8'h10
`define CPA_ADDR_RCOUNT  8'h14
`define CPA_ADDR_RSIZE   8'h18
`define CPA_ADDR_CONFIG  8'h1C
// control fields
`define CPA_CTRL_WRITE   0
`define CPA_CTRL_READ    1
// status fields
`define CPA_STAT_DONE    0
`define CPA_STAT_EOS     1
`define CPA_STAT_WEMPTY  2
`define CPA_STAT_RFULL   3
`define CPA_STAT_BUSY    4
// link clock timing
`define CPA_LINK_MIN_MHZ 25
`endif

//--- hdl/cpa_fifo.v
`include "cpa_defs.vh"
module cpa_fifo
#(
  parameter WIDTH = 32,
  parameter DEPTH = 64,
  parameter AW    = 6,
  parameter KIND  = 1
)
(
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             ce_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output reg  [WIDTH-1:0] out_data_o,
  output reg  [AW-1:0]    level_o
);
  // ---------------------------------------------------------------
  // storage: usable capacity is one below depth
  // ---------------------------------------------------------------
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp;
  reg [AW-1:0]    rp;
  reg             ov;
  wire [AW-1:0] wp_n = wp + {{(AW-1){1'b0}}, 1'b1};
  wire [AW-1:0] wp_n2 = wp + {{(AW-2){1'b0}}, 2'b10};
  wire [AW-1:0] used = wp - rp + {{(AW-1){1'b0}}, ov};
  // the output register holds a word too, so stop one short of depth
  wire full  = (wp_n == rp) || (ov && (wp_n2 == rp));
  wire empty = (wp == rp);
  wire push  = in_valid_i && !full && ce_i;
  wire pop   = out_valid_o && out_ready_i && ce_i;
  wire [AW-1:0] rp_n = rp + {{(AW-1){1'b0}}, 1'b1};
  wire load  = !empty && (!ov || pop);

  assign in_ready_o  = !full;
  assign out_valid_o = ov;

  always @(posedge clk_i)
  begin
    if (push)
      mem[wp] <= in_data_i;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wp      <= {AW{1'b0}};
      rp      <= {AW{1'b0}};
      ov      <= 1'b0;
      level_o <= {AW{1'b0}};
      out_data_o <= {WIDTH{1'b0}};
    end
    else if (ce_i)
    begin
      if (push)
        wp <= wp_n;
      if (load)
      begin
        out_data_o <= mem[rp];
        rp <= rp_n;
        ov <= 1'b1;
      end
      else if (pop)
        ov <= 1'b0;
      level_o <= used;
    end
  end
endmodule

//--- hdl/cpa_ctrl.v
// The Wishbone interface to the registers and the address map are this design's own decisions.
`include "cpa_defs.vh"
module cpa_ctrl
#(
  parameter CONFIG_PORT_WIDTH   = 32,
  parameter OMIT_WRITE_FIFO     = 0,
  parameter OMIT_READ_FIFO      = 0,
  parameter ENABLE_ASYNC        = 0,
  parameter ADVANCED_OPERATION  = 0,
  parameter FIFO_MEMORY_KIND    = 1,
  parameter WRITE_FIFO_DEPTH    = 64,
  parameter READ_FIFO_DEPTH     = 128,
  parameter INCLUDE_STARTUP_BLOCK = 0,
  parameter SHARE_STARTUP_PORTS = 0,
  parameter PORT_EXTERNAL       = 0
)
(
  input  wire                         clk_i,
  input  wire                         rst_i,
  input  wire                         ce_i,
  input  wire                         wb_cyc_i,
  input  wire                         wb_stb_i,
  input  wire                         wb_we_i,
  input  wire [7:0]                   wb_adr_i,
  input  wire [3:0]                   wb_sel_i,
  input  wire [31:0]                  wb_dat_i,
  output reg  [31:0]                  wb_dat_o,
  output reg                          wb_ack_o,
  input  wire                         port_clk_i,
  input  wire                         end_of_startup_i,
  output reg                          port_csn_o,
  output reg                          port_rdwrn_o,
  output reg  [CONFIG_PORT_WIDTH-1:0] port_dat_o,
  input  wire [CONFIG_PORT_WIDTH-1:0] port_dat_i,
  output wire                         port_clk_en_o,
  output wire                         startup_share_o
);
  // ---------------------------------------------------------------
  // build checks
  // ---------------------------------------------------------------
  localparam W_OMIT = (OMIT_WRITE_FIFO != 0) && (ENABLE_ASYNC == 0);
  localparam R_OMIT = (OMIT_READ_FIFO != 0) && W_OMIT;
  localparam PW     = (CONFIG_PORT_WIDTH == 8)  ? 8 :
                      (CONFIG_PORT_WIDTH == 16) ? 16 : 32;
  localparam WAW = (WRITE_FIFO_DEPTH <= 64)  ? 6 :
                   (WRITE_FIFO_DEPTH <= 128) ? 7 :
                   (WRITE_FIFO_DEPTH <= 256) ? 8 :
                   (WRITE_FIFO_DEPTH <= 512) ? 9 : 10;
  localparam RAW = (READ_FIFO_DEPTH <= 128) ? 7 : 8;

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_WR   = 4'h2;
  localparam [3:0] ST_RD   = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  reg [1:0] lclk_s;
  reg [1:0] eos_s;
  reg       lclk_d;
  reg [CONFIG_PORT_WIDTH-1:0] pdat_s0;
  reg [CONFIG_PORT_WIDTH-1:0] pdat_s1;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lclk_s <= 2'h0;
      eos_s  <= 2'h0;
      lclk_d <= 1'b0;
      pdat_s0 <= {CONFIG_PORT_WIDTH{1'b0}};
      pdat_s1 <= {CONFIG_PORT_WIDTH{1'b0}};
    end
    else if (ce_i)
    begin
      lclk_s <= {lclk_s[0], port_clk_i};
      eos_s  <= {eos_s[0], end_of_startup_i};
      lclk_d <= lclk_s[1];
      pdat_s0 <= port_dat_i;
      pdat_s1 <= pdat_s0;
    end
  end
  // async: act on sampled rising edges of the port clock; sync: every cycle
  wire tick = (ENABLE_ASYNC != 0) ? (lclk_s[1] && !lclk_d) : 1'b1;
  wire eos_ok = (INCLUDE_STARTUP_BLOCK == 0) || eos_s[1];
  // async: port data comes from the other domain, take it after two flops
  wire [CONFIG_PORT_WIDTH-1:0] pdat = (ENABLE_ASYNC != 0) ? pdat_s1 :
                                      port_dat_i;

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  reg  [3:0]  state;
  reg  [3:0]  next_state;
  reg  [1:0]  ctrl;
  reg  [31:0] rsize;
  reg  [31:0] rcnt;
  reg  [31:0] lite_word;
  reg         lite_full;
  wire        req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  wire        wr  = req && wb_we_i;
  wire        rd  = req && !wb_we_i;
  wire        busy = !state[0];

  wire        wf_in_ready;
  wire        wf_valid;
  wire [31:0] wf_data;
  wire [WAW-1:0] wf_level;
  wire        rf_in_ready;
  wire        rf_valid;
  wire [31:0] rf_data;
  wire [RAW-1:0] rf_level;
  wire        wf_pop;
  wire        rf_push;
  wire        rf_pop = rd && (wb_adr_i == `CPA_ADDR_RFIFO) && rf_valid;
  wire        wf_push = wr && (wb_adr_i == `CPA_ADDR_WFIFO) && wb_sel_i[0];

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      ctrl     <= 2'h0;
      rsize    <= 32'h0;
    end
    else if (ce_i)
    begin
      wb_ack_o <= req;
      if (state == ST_DONE)
        ctrl <= 2'h0;
      if (wr && wb_adr_i == `CPA_ADDR_CTRL && !busy && wb_sel_i[0])
        ctrl <= wb_dat_i[1:0];
      else if (wr && wb_adr_i == `CPA_ADDR_RSIZE && !busy)
        rsize <= wb_dat_i;
      if (rd)
      begin
        if (wb_adr_i == `CPA_ADDR_RFIFO)
          wb_dat_o <= R_OMIT ? 32'h0 : rf_data;
        else if (wb_adr_i == `CPA_ADDR_CTRL)
          wb_dat_o <= {30'h0, ctrl};
        else if (wb_adr_i == `CPA_ADDR_STATUS)
          wb_dat_o <= {27'h0, busy, !rf_in_ready, !wf_valid,
                       eos_s[1], !busy};
        else if (wb_adr_i == `CPA_ADDR_WCOUNT)
          wb_dat_o <= {{(32-WAW){1'b0}}, wf_level};
        else if (wb_adr_i == `CPA_ADDR_RCOUNT)
          wb_dat_o <= {{(32-RAW){1'b0}}, rf_level};
        else if (wb_adr_i == `CPA_ADDR_RSIZE)
          wb_dat_o <= rsize;
        else if (wb_adr_i == `CPA_ADDR_CONFIG)
          wb_dat_o <= {26'h0, R_OMIT[0], W_OMIT[0], PW[5:2]};
        else
          wb_dat_o <= 32'h0;
      end
    end
  end

  // ---------------------------------------------------------------
  // write path: fifo or single holding word when omitted
  // ---------------------------------------------------------------
  generate
    if (W_OMIT)
    begin : g_nowf
      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          lite_word <= 32'h0;
          lite_full <= 1'b0;
        end
        else if (ce_i)
        begin
          if (wf_push && !lite_full)
          begin
            lite_word <= wb_dat_i;
            lite_full <= 1'b1;
          end
          else if (wf_pop)
            lite_full <= 1'b0;
        end
      end
      assign wf_valid    = lite_full;
      assign wf_data     = lite_word;
      assign wf_in_ready = !lite_full;
      assign wf_level    = {{(WAW-1){1'b0}}, lite_full};
    end
    else
    begin : g_wf
      always @(posedge clk_i)
      begin
        lite_word <= 32'h0;
        lite_full <= 1'b0;
      end
      cpa_fifo #(
        .WIDTH (32),
        .DEPTH (WRITE_FIFO_DEPTH),
        .AW    (WAW),
        .KIND  (FIFO_MEMORY_KIND)
      ) u_wf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .in_valid_i  (wf_push),
        .in_ready_o  (wf_in_ready),
        .in_data_i   (wb_dat_i),
        .out_valid_o (wf_valid),
        .out_ready_i (wf_pop),
        .out_data_o  (wf_data),
        .level_o     (wf_level)
      );
    end
    if (R_OMIT)
    begin : g_norf
      assign rf_in_ready = 1'b1;
      assign rf_valid    = 1'b0;
      assign rf_data     = 32'h0;
      assign rf_level    = {RAW{1'b0}};
    end
    else
    begin : g_rf
      cpa_fifo #(
        .WIDTH (32),
        .DEPTH (READ_FIFO_DEPTH),
        .AW    (RAW),
        .KIND  (FIFO_MEMORY_KIND)
      ) u_rf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .in_valid_i  (rf_push),
        .in_ready_o  (rf_in_ready),
        .in_data_i   ({{(32-PW){1'b0}}, pdat}),
        .out_valid_o (rf_valid),
        .out_ready_i (rf_pop),
        .out_data_o  (rf_data),
        .level_o     (rf_level)
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // port sequencer
  // ---------------------------------------------------------------
  wire go    = tick && eos_ok;
  wire rdone = (rcnt == rsize);
  assign wf_pop  = (state == ST_WR) && go && wf_valid;
  assign rf_push = (state == ST_RD) && go && !port_csn_o && port_rdwrn_o
                   && !rdone;

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (ctrl[`CPA_CTRL_WRITE])
          next_state = ST_WR;
        else if (ctrl[`CPA_CTRL_READ])
          next_state = ST_RD;
      ST_WR:
        if (go && !wf_valid)
          next_state = ST_DONE;
      ST_RD:
        if (go && (rdone || (R_OMIT && 1'b1)))
          next_state = ST_DONE;
      ST_DONE:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state        <= ST_IDLE;
      rcnt         <= 32'h0;
      port_csn_o   <= 1'b1;
      port_rdwrn_o <= 1'b1;
      port_dat_o   <= {CONFIG_PORT_WIDTH{1'b0}};
    end
    else if (ce_i)
    begin
      state <= next_state;
      if (state == ST_IDLE)
        rcnt <= 32'h0;
      if (go)
      begin
        port_csn_o <= 1'b1;
        if (wf_pop)
        begin
          port_csn_o   <= 1'b0;
          port_rdwrn_o <= 1'b0;
          port_dat_o   <= wf_data[CONFIG_PORT_WIDTH-1:0];
        end
        else if (state == ST_RD && !rdone && rf_in_ready && !R_OMIT)
        begin
          port_csn_o   <= 1'b0;
          port_rdwrn_o <= 1'b1;
          if (rf_push)
            rcnt <= rcnt + 32'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // clock buffer enable and startup sharing
  // ---------------------------------------------------------------
  assign port_clk_en_o   = (ADVANCED_OPERATION != 0) ? busy : 1'b1;
  assign startup_share_o = (SHARE_STARTUP_PORTS != 0) &&
                           (INCLUDE_STARTUP_BLOCK != 0) &&
                           (PORT_EXTERNAL != 0 || 1'b1);
endmodule

//--- test/cpa_ctrl_assertions.sv
module cpa_ctrl_checker
#(
  parameter ADV     = 0,
  parameter SHARE   = 0,
  parameter STARTUP = 0
)
(
  input wire        clk_i,
  input wire        rst_i,
  input wire        ce_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        end_of_startup_i,
  input wire        port_csn_o,
  input wire        port_clk_en_o,
  input wire        startup_share_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o;
  endproperty
  a_answer: assert property (p_answer) else $error("ack missing");
  property p_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_cause: assert property (p_cause) else $error("ack unasked");
  property p_rst;
    disable iff (1'b0) rst_i |=> port_csn_o && !wb_ack_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_unmapped;
    wb_ack_o && $past(!wb_we_i && wb_adr_i > 8'h1F) |-> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_eos;
    !end_of_startup_i [*4] |-> (STARTUP == 0) || port_csn_o;
  endproperty
  a_eos: assert property (p_eos) else $error("port before startup");
  property p_clk_en;
    ADV == 0 |-> port_clk_en_o;
  endproperty
  a_clk_en: assert property (p_clk_en) else $error("clk gated");
  property p_share;
    startup_share_o == ((SHARE != 0) && (STARTUP != 0));
  endproperty
  a_share: assert property (p_share) else $error("share flag");
endmodule

bind cpa_ctrl cpa_ctrl_checker #(.ADV(ADVANCED_OPERATION),
  .SHARE(SHARE_STARTUP_PORTS), .STARTUP(INCLUDE_STARTUP_BLOCK))
  u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .end_of_startup_i(end_of_startup_i),
  .port_csn_o(port_csn_o), .port_clk_en_o(port_clk_en_o),
  .startup_share_o(startup_share_o));

//--- test/cpa_port_model.sv
module cpa_port_model
#(
  parameter W = 16
)
(
  input  wire          clk_i,
  input  wire          csn_i,
  input  wire          rdwrn_i,
  input  wire [W-1:0]  wdat_i,
  output wire [W-1:0]  rdat_o,
  output logic [W-1:0] sum_o,
  output int           n_wr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam [31:0] PAT = 32'hC35A_0F96;
  // inverse pattern whenever not selected for reading
  assign rdat_o = (!csn_i && rdwrn_i) ? PAT[W-1:0] : ~PAT[W-1:0];
  initial
  begin
    sum_o = '0;
    n_wr_o = 0;
  end
  // one word per port clock while selected for writing
  always @(posedge clk_i)
  begin
    if (!csn_i && !rdwrn_i)
    begin
      sum_o <= sum_o + wdat_i;
      n_wr_o <= n_wr_o + 1;
    end
  end
endmodule

//--- test/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam        W   = 16;
  localparam [31:0] PAT = 32'hC35A_0F96;
  logic             clk_i, rst_i, port_clk, end_of_startup, cyc, stb, we;
  logic [7:0]       adr;
  logic [31:0]      wdat;
  wire  [31:0]      rdat;
  wire  [31:0]      rdat_lite;
  logic [31:0]      q_lite;
  wire              ack, csn, rdwrn;
  wire  [W-1:0]     pdo, pdi, psum;
  int               n_wr, n_fail, n_checks;
  cpa_ctrl #(.CONFIG_PORT_WIDTH(W), .ENABLE_ASYNC(1),
    .INCLUDE_STARTUP_BLOCK(1), .SHARE_STARTUP_PORTS(1)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .port_clk_i(port_clk), .end_of_startup_i(end_of_startup), .port_csn_o(csn),
    .port_rdwrn_o(rdwrn), .port_dat_o(pdo), .port_dat_i(pdi),
    .port_clk_en_o(), .startup_share_o());
  cpa_port_model #(.W(W)) i_port (.clk_i(port_clk), .csn_i(csn),
    .rdwrn_i(rdwrn), .wdat_i(pdo), .rdat_o(pdi), .sum_o(psum),
    .n_wr_o(n_wr));
  // second build: both fifos left out, bus and port clock shared
  cpa_ctrl #(.OMIT_WRITE_FIFO(1), .OMIT_READ_FIFO(1)) i_dut_lite (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat_lite), .wb_ack_o(),
    .port_clk_i(port_clk), .end_of_startup_i(end_of_startup), .port_csn_o(),
    .port_rdwrn_o(), .port_dat_o(), .port_dat_i(32'hFFFF_FFFF),
    .port_clk_en_o(), .startup_share_o());
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1 && k < 50);
    q = rdat;
    q_lite = rdat_lite;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 50)
    begin
      n_fail++;
      final_report;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask
  task automatic wait_done;
    logic [31:0] q;
    int k;
    k = 0;
    do
    begin
      wb(1'b0, 8'h08, 32'h0, q);
      k++;
    end
    while (q[1:0] !== 2'b00 && k < 1000);
    check(q, 32'h0);
    if (k >= 1000)
      final_report;
  endtask
  function automatic logic [31:0] dw(input int i);
    return 32'h5A00_0000 + i * 32'h0001_0101;
  endfunction
  task automatic t_idle;
    rd(8'h08, 32'h0);
    rd(8'h10, 32'h0);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0);
    $display("test idle done");
  endtask
  task automatic t_fill;
    for (int i = 0; i < 64; i++)
      wr(8'h00, dw(i));
    rd(8'h10, 32'h3F);
    $display("test fill done");
  endtask
  task automatic t_eos;
    logic [W-1:0] es;
    es = '0;
    wr(8'h08, 32'h1);
    repeat (40) @(posedge clk_i);
    check(32'(n_wr), 32'h0);
    rd(8'h08, 32'h1);
    end_of_startup <= 1'b1;
    wait_done;
    for (int i = 0; i < 63; i++)
      es += W'(dw(i));
    check(32'(n_wr), 32'h3F);
    check(32'(psum), 32'(es));
    rd(8'h10, 32'h0);
    $display("test write done");
  endtask
  task automatic t_read;
    logic [31:0] q;
    wr(8'h18, 32'h4);
    wr(8'h08, 32'h2);
    wait_done;
    rd(8'h14, 32'h4);
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b0, 8'h04, 32'h0, q);
      check(32'(q[W-1:0]), 32'(PAT[W-1:0]));
    end
    rd(8'h14, 32'h0);
    $display("test read done");
  endtask
  task automatic t_lite;
    logic [31:0] q;
    wb(1'b0, 8'h04, 32'h0, q);
    check(q_lite, 32'h0000_0000);
    wb(1'b0, 8'h1C, 32'h0, q);
    check(q_lite, 32'h0000_0038);
    check(q, 32'h0000_0004);
    $display("test lite done");
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial
  begin
    port_clk = 1'b0;
    #7;
    forever #16 port_clk = ~port_clk;
  end
  initial
  begin
    rst_i = 1'b1;
    end_of_startup = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_idle;
    t_fill;
    t_eos;
    t_read;
    t_lite;
    final_report;
  end
endmodule
